// ==== hw/core_pkg.sv ====
// constants, opcodes and register map of the instruction timing core
package core_pkg;
  // ************************************************************
  // instruction timing
  // ************************************************************
  localparam int CLOCKS_PER_ICYCLE = 4;
  localparam logic [1:0] LAST_PHASE = 2'h3;
  localparam int PCLK_HZ = 20_000_000;
  localparam int PCLK_NS = 1_000_000_000 / PCLK_HZ;
  localparam int ICYCLE_NS = CLOCKS_PER_ICYCLE * PCLK_NS;
  localparam int REF_SYS_CLK_MHZ = 8;
  localparam int REF_ONE_CYCLE_NS = CLOCKS_PER_ICYCLE * 1000 / REF_SYS_CLK_MHZ;
  localparam int REF_TWO_CYCLE_NS = 2 * REF_ONE_CYCLE_NS;
  // ************************************************************
  // memories and instruction fields
  // ************************************************************
  localparam int PROG_DEPTH = 2048;
  localparam int DMEM_DEPTH = 128;
  localparam int STACK_DEPTH = 4;
  localparam int OPC_MSB = 15;
  localparam int OPC_LSB = 11;
  localparam int BSEL_MSB = 10;
  localparam int BSEL_LSB = 8;
  localparam int ROT_ACC_BIT = 8;
  localparam int ROT_CARRY_BIT = 9;
  localparam int ROT_LEFT_BIT = 10;
  localparam logic [6:0] PCL_ADDR = 7'h02;
  localparam logic [10:0] RST_PC = 11'h000;
  localparam logic [7:0] RST_ACC = 8'h00;
  // ************************************************************
  // apb register map
  // ************************************************************
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_PC = 12'h008;
  localparam logic [11:0] OFF_ACC = 12'h00c;
  localparam logic [11:0] OFF_PROG_ADDR = 12'h010;
  localparam logic [11:0] OFF_PROG_DATA = 12'h014;
  localparam logic [11:0] OFF_DMEM_ADDR = 12'h018;
  localparam logic [11:0] OFF_DMEM_DATA = 12'h01c;
  localparam logic [11:0] OFF_ICYCLES = 12'h020;
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_GIE_BIT = 1;
  localparam int STAT_Z_BIT = 0;
  localparam int STAT_C_BIT = 1;
  localparam int STAT_GIE_BIT = 2;
  localparam int STAT_HALT_BIT = 3;
  localparam int STAT_FLUSH_BIT = 4;
  // ************************************************************
  // opcodes and sequencer states
  // ************************************************************
  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_TO_ACC_M = 5'h01, OP_TO_MEM = 5'h02, OP_TO_ACC_X = 5'h03,
    OP_ADD_M = 5'h04, OP_ADD_X = 5'h05, OP_SUB_M = 5'h06, OP_SUB_X = 5'h07,
    OP_AND_M = 5'h08, OP_OR_M = 5'h09, OP_XOR_M = 5'h0a, OP_AND_X = 5'h0b,
    OP_OR_X = 5'h0c, OP_XOR_X = 5'h0d, OP_INVERT_M = 5'h0e, OP_INVERT_A = 5'h0f,
    OP_PLUS_M = 5'h10, OP_PLUS_A = 5'h11, OP_MINUS_M = 5'h12, OP_MINUS_A = 5'h13,
    OP_ROTATE = 5'h14, OP_BIT_HIGH = 5'h15, OP_BIT_LOW = 5'h16, OP_SKIP_ZERO = 5'h17,
    OP_SKIP_BIT_ZERO = 5'h18, OP_SKIP_BIT_ONE = 5'h19, OP_JUMP = 5'h1a, OP_CALL = 5'h1b,
    OP_RETURN = 5'h1c, OP_RETURN_INT = 5'h1d, OP_TABLE_READ = 5'h1e, OP_HALT = 5'h1f
  } opcode_e;
  typedef enum logic [1:0] {
    ST_STOP = 2'h0,
    ST_EXEC = 2'h1,
    ST_FLUSH = 2'h2,
    ST_HALT = 2'h3
  } core_state_e;
endpackage

// ==== hw/core_alu.sv ====
// arithmetic, rotate and single-bit primitives of the data path
module core_alu (
  // operands
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic [7:0] m,
  input wire logic cin,
  // selectors
  input wire logic [2:0] bsel,
  input wire logic rot_left,
  input wire logic rot_carry,
  // results
  output logic [8:0] sum9,
  output logic [8:0] diff9,
  output logic [7:0] plus1,
  output logic [7:0] minus1,
  output logic [7:0] rot,
  output logic rot_cout,
  output logic [7:0] bit_high,
  output logic [7:0] bit_low
);
  logic [7:0] mask;
  logic fill_r;
  logic fill_l;
  // ninth bit is carry on add and borrow on subtract
  assign sum9 = {1'b0, a} + {1'b0, b};
  assign diff9 = {1'b0, a} - {1'b0, b};
  assign plus1 = m + 8'h01;
  assign minus1 = m - 8'h01;
  assign fill_r = rot_carry ? cin : m[0];
  assign fill_l = rot_carry ? cin : m[7];
  assign rot = rot_left ? {m[6:0], fill_l} : {fill_r, m[7:1]};
  assign rot_cout = rot_left ? m[7] : m[0];
  assign mask = 8'h01 << bsel;
  assign bit_high = m | mask;
  assign bit_low = m & ~mask;
endmodule

// ==== hw/return_stack.sv ====
// return address stack for subroutine entry and exit
module return_stack (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic push,
  input wire logic pop,
  input wire logic [10:0] push_addr,
  // top entry
  output logic [10:0] top
);
  logic [10:0] slot [0:core_pkg::STACK_DEPTH-1];
  logic [1:0] sp;
  logic [1:0] sp_top;
  assign sp_top = sp - 2'h1;
  assign top = slot[sp_top];
  // a fifth nested entry silently overwrites the oldest one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp <= 2'h0;
    end else if (push) begin
      sp <= sp + 2'h1;
    end else if (pop) begin
      sp <= sp_top;
    end
  end
  always_ff @(posedge pclk) begin
    if (push) begin
      slot[sp] <= push_addr;
    end
  end
endmodule

// ==== hw/mcu_instruction_timing_core.sv ====
// instruction timing core: phase sequencing, decode, program counter and apb slave
//
// Decided for this implementation: the register offsets and register access over APB.
module mcu_instruction_timing_core (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  // ************************************************************
  // storage
  // ************************************************************
  logic [15:0] prog [0:core_pkg::PROG_DEPTH-1];
  logic [7:0] dmem [0:core_pkg::DMEM_DEPTH-1];

  // ************************************************************
  // architectural and control state
  // ************************************************************
  logic [1:0] phase;
  core_pkg::core_state_e state;
  core_pkg::core_state_e next_state;
  logic [10:0] pc;
  logic [10:0] next_pc;
  logic [7:0] acc;
  logic zf;
  logic cf;
  logic global_interrupt_allow;
  logic ctrl_run;
  logic [10:0] prog_addr;
  logic [6:0] dmem_addr;
  logic [31:0] icycles;

  // ************************************************************
  // decode
  // ************************************************************
  logic [15:0] instr;
  core_pkg::opcode_e op;
  logic [2:0] bsel;
  logic [7:0] imm;
  logic [6:0] m_addr;
  logic [10:0] target;
  logic m_is_pcl;
  logic [7:0] mval;
  logic uses_imm;
  logic [7:0] opnd;
  logic [10:0] tbl_index;
  logic [15:0] tbl_word;
  logic [10:0] pc_inc;
  logic [10:0] pc_skip;
  logic [10:0] stack_top;
  logic is_branch;
  logic pcl_write;
  logic two_cycle;
  logic boundary;
  logic exec;

  function automatic logic is_zero(input logic [7:0] v);
    is_zero = (v == 8'h00);
  endfunction

  assign instr = prog[pc];
  assign op = core_pkg::opcode_e'(instr[core_pkg::OPC_MSB:core_pkg::OPC_LSB]);
  assign bsel = instr[core_pkg::BSEL_MSB:core_pkg::BSEL_LSB];
  assign imm = instr[7:0];
  assign m_addr = instr[6:0];
  assign target = instr[10:0];
  // the low byte of the program counter is visible as a data location
  assign m_is_pcl = (m_addr == core_pkg::PCL_ADDR);
  assign mval = m_is_pcl ? pc[7:0] : dmem[m_addr];
  assign uses_imm = (op == core_pkg::OP_TO_ACC_X) || (op == core_pkg::OP_ADD_X) ||
                    (op == core_pkg::OP_SUB_X) || (op == core_pkg::OP_AND_X) ||
                    (op == core_pkg::OP_OR_X) || (op == core_pkg::OP_XOR_X);
  assign opnd = uses_imm ? imm : mval;
  assign tbl_index = {pc[10:8], acc};
  assign tbl_word = prog[tbl_index];
  assign pc_inc = pc + 11'h001;
  assign pc_skip = pc + 11'h002;

  // ************************************************************
  // data path
  // ************************************************************
  logic [8:0] sum9;
  logic [8:0] diff9;
  logic [7:0] plus1;
  logic [7:0] minus1;
  logic [7:0] rot;
  logic rot_cout;
  logic [7:0] bit_high;
  logic [7:0] bit_low;

  core_alu u_alu (
    .a(acc),
    .b(opnd),
    .m(mval),
    .cin(cf),
    .bsel(bsel),
    .rot_left(instr[core_pkg::ROT_LEFT_BIT]),
    .rot_carry(instr[core_pkg::ROT_CARRY_BIT]),
    .sum9(sum9),
    .diff9(diff9),
    .plus1(plus1),
    .minus1(minus1),
    .rot(rot),
    .rot_cout(rot_cout),
    .bit_high(bit_high),
    .bit_low(bit_low)
  );

  logic [7:0] res;
  logic c_new;
  logic wr_acc;
  logic wr_mem;
  logic wr_c;
  logic wr_z;
  logic skip;

  always_comb begin
    res = mval;
    c_new = cf;
    wr_acc = 1'b0;
    wr_mem = 1'b0;
    wr_c = 1'b0;
    wr_z = 1'b0;
    skip = 1'b0;
    case (op)
      core_pkg::OP_TO_ACC_M, core_pkg::OP_TO_ACC_X: begin
        res = opnd;
        wr_acc = 1'b1;
      end
      core_pkg::OP_TO_MEM: begin
        res = acc;
        wr_mem = 1'b1;
      end
      core_pkg::OP_ADD_M, core_pkg::OP_ADD_X: begin
        res = sum9[7:0];
        c_new = sum9[8];
        wr_acc = 1'b1;
        wr_c = 1'b1;
        wr_z = 1'b1;
      end
      core_pkg::OP_SUB_M, core_pkg::OP_SUB_X: begin
        res = diff9[7:0];
        c_new = diff9[8];
        wr_acc = 1'b1;
        wr_c = 1'b1;
        wr_z = 1'b1;
      end
      core_pkg::OP_AND_M, core_pkg::OP_AND_X: begin
        res = acc & opnd;
        wr_acc = 1'b1;
        wr_z = 1'b1;
      end
      core_pkg::OP_OR_M, core_pkg::OP_OR_X: begin
        res = acc | opnd;
        wr_acc = 1'b1;
        wr_z = 1'b1;
      end
      core_pkg::OP_XOR_M, core_pkg::OP_XOR_X: begin
        res = acc ^ opnd;
        wr_acc = 1'b1;
        wr_z = 1'b1;
      end
      core_pkg::OP_INVERT_M, core_pkg::OP_INVERT_A: begin
        res = ~mval;
        wr_mem = (op == core_pkg::OP_INVERT_M);
        wr_acc = (op == core_pkg::OP_INVERT_A);
        wr_z = 1'b1;
      end
      core_pkg::OP_PLUS_M, core_pkg::OP_PLUS_A: begin
        res = plus1;
        wr_mem = (op == core_pkg::OP_PLUS_M);
        wr_acc = (op == core_pkg::OP_PLUS_A);
        wr_z = 1'b1;
      end
      core_pkg::OP_MINUS_M, core_pkg::OP_MINUS_A: begin
        res = minus1;
        wr_mem = (op == core_pkg::OP_MINUS_M);
        wr_acc = (op == core_pkg::OP_MINUS_A);
        wr_z = 1'b1;
      end
      core_pkg::OP_ROTATE: begin
        res = rot;
        c_new = rot_cout;
        wr_c = instr[core_pkg::ROT_CARRY_BIT];
        wr_acc = instr[core_pkg::ROT_ACC_BIT];
        wr_mem = !instr[core_pkg::ROT_ACC_BIT];
      end
      core_pkg::OP_BIT_HIGH: begin
        res = bit_high;
        wr_mem = 1'b1;
      end
      core_pkg::OP_BIT_LOW: begin
        res = bit_low;
        wr_mem = 1'b1;
      end
      core_pkg::OP_SKIP_ZERO: begin
        skip = is_zero(mval);
      end
      core_pkg::OP_SKIP_BIT_ZERO: begin
        skip = !mval[bsel];
      end
      core_pkg::OP_SKIP_BIT_ONE: begin
        skip = mval[bsel];
      end
      core_pkg::OP_TABLE_READ: begin
        res = tbl_word[7:0];
        wr_mem = 1'b1;
      end
      default: begin
        res = mval;
      end
    endcase
  end

  // ************************************************************
  // sequencing
  // ************************************************************
  assign is_branch = (op == core_pkg::OP_JUMP) || (op == core_pkg::OP_CALL) ||
                     (op == core_pkg::OP_RETURN) || (op == core_pkg::OP_RETURN_INT);
  assign pcl_write = wr_mem && m_is_pcl;
  // a skip, a branch, a table read or a new low byte costs a second cycle
  assign two_cycle = is_branch || (op == core_pkg::OP_TABLE_READ) || pcl_write || skip;
  assign boundary = (phase == core_pkg::LAST_PHASE);
  // run is rechecked so a cleared run bit stops execution at the next boundary
  assign exec = boundary && (state == core_pkg::ST_EXEC) && ctrl_run;

  always_comb begin
    case (op)
      core_pkg::OP_JUMP, core_pkg::OP_CALL: begin
        next_pc = target;
      end
      core_pkg::OP_RETURN, core_pkg::OP_RETURN_INT: begin
        next_pc = stack_top;
      end
      default: begin
        if (pcl_write) begin
          next_pc = {pc[10:8], res};
        end else if (skip) begin
          next_pc = pc_skip;
        end else begin
          next_pc = pc_inc;
        end
      end
    endcase
  end

  always_comb begin
    next_state = state;
    case (state)
      core_pkg::ST_STOP: begin
        if (ctrl_run) begin
          next_state = core_pkg::ST_EXEC;
        end
      end
      core_pkg::ST_EXEC: begin
        if (!ctrl_run) begin
          next_state = core_pkg::ST_STOP;
        end else if (op == core_pkg::OP_HALT) begin
          next_state = core_pkg::ST_HALT;
        end else if (two_cycle) begin
          next_state = core_pkg::ST_FLUSH;
        end
      end
      core_pkg::ST_FLUSH: begin
        next_state = ctrl_run ? core_pkg::ST_EXEC : core_pkg::ST_STOP;
      end
      core_pkg::ST_HALT: begin
        if (!ctrl_run) begin
          next_state = core_pkg::ST_STOP;
        end
      end
      default: begin
        next_state = core_pkg::ST_STOP;
      end
    endcase
  end

  return_stack u_stack (
    .pclk(pclk),
    .presetn(presetn),
    .push(exec && (op == core_pkg::OP_CALL)),
    .pop(exec && ((op == core_pkg::OP_RETURN) || (op == core_pkg::OP_RETURN_INT))),
    .push_addr(pc_inc),
    .top(stack_top)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= core_pkg::ST_STOP;
    end else if (boundary) begin
      state <= next_state;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc <= core_pkg::RST_PC;
    end else if (exec) begin
      pc <= next_pc;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc <= core_pkg::RST_ACC;
    end else if (exec && wr_acc) begin
      acc <= res;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cf <= 1'b0;
      zf <= 1'b0;
    end else if (exec) begin
      cf <= wr_c ? c_new : cf;
      zf <= wr_z ? is_zero(res) : zf;
    end
  end

  // ************************************************************
  // apb slave, software access and cycle counter
  // ************************************************************
  logic apb_setup;
  logic apb_wr;
  logic wr_ctrl;
  logic wr_prog;
  logic wr_dmem;
  logic ret_int;
  logic count_icycle;
  logic addr_ok;
  logic [7:0] status;
  logic [31:0] rd_word;

  // one wait state: ready is raised on the second access cycle
  assign apb_setup = psel && penable && !pready;
  assign apb_wr = psel && penable && pready && pwrite;
  assign wr_ctrl = apb_wr && (paddr == core_pkg::OFF_CTRL);
  assign wr_prog = apb_wr && (paddr == core_pkg::OFF_PROG_DATA);
  assign wr_dmem = apb_wr && (paddr == core_pkg::OFF_DMEM_DATA);
  assign ret_int = exec && (op == core_pkg::OP_RETURN_INT);
  // a flushed slot is still a whole instruction cycle spent
  assign count_icycle = boundary && (exec || (state == core_pkg::ST_FLUSH));
  assign status = {3'h0, state == core_pkg::ST_FLUSH, state == core_pkg::ST_HALT,
                   global_interrupt_allow, cf, zf};

  always_comb begin
    rd_word = 32'h0000_0000;
    addr_ok = 1'b1;
    if (paddr == core_pkg::OFF_CTRL) begin
      rd_word = {30'h0000_0000, global_interrupt_allow, ctrl_run};
    end else if (paddr == core_pkg::OFF_STATUS) begin
      rd_word = {24'h00_0000, status};
    end else if (paddr == core_pkg::OFF_PC) begin
      rd_word = {21'h00_0000, pc};
    end else if (paddr == core_pkg::OFF_ACC) begin
      rd_word = {24'h00_0000, acc};
    end else if (paddr == core_pkg::OFF_PROG_ADDR) begin
      rd_word = {21'h00_0000, prog_addr};
    end else if (paddr == core_pkg::OFF_PROG_DATA) begin
      rd_word = {16'h0000, prog[prog_addr]};
    end else if (paddr == core_pkg::OFF_DMEM_ADDR) begin
      rd_word = {25'h000_0000, dmem_addr};
    end else if (paddr == core_pkg::OFF_DMEM_DATA) begin
      rd_word = {24'h00_0000, dmem[dmem_addr]};
    end else if (paddr == core_pkg::OFF_ICYCLES) begin
      rd_word = icycles;
    end else begin
      addr_ok = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup && !addr_ok;
      if (apb_setup && !pwrite) begin
        prdata <= rd_word;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_run <= 1'b0;
      global_interrupt_allow <= 1'b0;
      prog_addr <= 11'h000;
      dmem_addr <= 7'h00;
    end else begin
      if (wr_ctrl) begin
        ctrl_run <= pwdata[core_pkg::CTRL_RUN_BIT];
      end
      // the return wins over a software clear in the same cycle
      if (ret_int) begin
        global_interrupt_allow <= 1'b1;
      end else if (wr_ctrl) begin
        global_interrupt_allow <= pwdata[core_pkg::CTRL_GIE_BIT];
      end
      if (apb_wr && (paddr == core_pkg::OFF_PROG_ADDR)) begin
        prog_addr <= pwdata[10:0];
      end
      if (apb_wr && (paddr == core_pkg::OFF_DMEM_ADDR)) begin
        dmem_addr <= pwdata[6:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      icycles <= 32'h0000_0000;
    end else if (count_icycle) begin
      icycles <= icycles + 32'h0000_0001;
    end
  end

  always_ff @(posedge pclk) begin
    if (wr_prog) begin
      prog[prog_addr] <= pwdata[15:0];
    end
  end

  // the core has priority; software should load memory while stopped
  always_ff @(posedge pclk) begin
    if (exec && wr_mem && !m_is_pcl) begin
      dmem[m_addr] <= res;
    end else if (wr_dmem) begin
      dmem[dmem_addr] <= pwdata[7:0];
    end
  end
endmodule

// ==== tb/core_asserts.sv ====
// concurrent checks on the apb ports of the instruction timing core
module core_asserts (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // ************************************************************
  // helper logic
  // ************************************************************
  logic [31:0] last_icy;
  logic seen_icy;
  wire logic rd_done = psel && penable && pready && !pwrite;
  wire logic icy_rd = rd_done && (paddr == core_pkg::OFF_ICYCLES);
  wire logic stat_rd = rd_done && (paddr == core_pkg::OFF_STATUS);
  // the count is only compared within one reset period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_icy <= 32'h0000_0000;
      seen_icy <= 1'b0;
    end else if (icy_rd) begin
      last_icy <= prdata;
      seen_icy <= 1'b1;
    end
  end
  // ************************************************************
  // assertions
  // ************************************************************
  AST_ACCESS_ENDS: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable |-> ##[0:15] pready)
    else $error("apb access not answered in time");
  AST_ICY_GROWS: assert property (@(posedge pclk) disable iff (!presetn)
    icy_rd && seen_icy |-> prdata >= last_icy)
    else $error("instruction cycle count went back");
  AST_READY_ONE_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !pready |=> pready)
    else $error("ready not raised after one wait state");
  AST_READY_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held longer than one cycle");
  AST_READY_IN_ACCESS: assert property (@(posedge pclk) disable iff (!presetn)
    pready |-> psel && penable)
    else $error("ready outside an access phase");
  AST_STATE_EXCLUSIVE: assert property (@(posedge pclk) disable iff (!presetn)
    stat_rd |-> !(prdata[core_pkg::STAT_HALT_BIT] && prdata[core_pkg::STAT_FLUSH_BIT]))
    else $error("halt and flush reported together");
  cover property (@(posedge pclk) disable iff (!presetn) icy_rd);
  cover property (@(posedge pclk) disable iff (!presetn)
    stat_rd && prdata[core_pkg::STAT_HALT_BIT]);
  cover property (@(posedge pclk) disable iff (!presetn) psel && penable && pready && pwrite);
endmodule

bind mcu_instruction_timing_core core_asserts core_asserts_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
);

// ==== tb/testbench.sv ====
// self-checking bench of the instruction timing core
`define CHECK(g, e) begin total_checks++; if ((g) !== (e)) begin fails++; \
  $display("Error t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  int fails = 0;
  int total_checks = 0;
  typedef struct {logic [31:0] e; logic [31:0] m;} note_s;
  note_s notes[$];
  note_s cur;
  logic [15:0] prog[$];
  always #25 pclk = ~pclk;
  mcu_instruction_timing_core mcu_instruction_timing_core_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
  );
  // ************************************************************
  // result watcher
  // ************************************************************
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && notes.size() > 0) begin
      cur = notes.pop_front();
      if (cur.m != 0) `CHECK(prdata & cur.m, cur.e)
    end
  end
  // ************************************************************
  // tasks
  // ************************************************************
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 64) begin
      fails++;
      complete_run();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
    logic [31:0] r;
    notes.push_back('{e, m});
    apb(1'b0, a, 32'h0000_0000, r);
  endtask
  task automatic start();
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  task automatic poke(input logic [7:0] a, input logic [7:0] v);
    wr(core_pkg::OFF_DMEM_ADDR, {24'h0, a});
    wr(core_pkg::OFF_DMEM_DATA, {24'h0, v});
  endtask
  task automatic peek(input logic [7:0] a, input logic [7:0] v);
    wr(core_pkg::OFF_DMEM_ADDR, {24'h0, a});
    rd(core_pkg::OFF_DMEM_DATA, {24'h0, v}, 32'h0000_00ff);
  endtask
  task automatic run();
    logic [31:0] r;
    int n;
    foreach (prog[i]) begin
      wr(core_pkg::OFF_PROG_ADDR, 32'(i));
      wr(core_pkg::OFF_PROG_DATA, {16'h0, prog[i]});
    end
    wr(core_pkg::OFF_CTRL, 32'h1 << core_pkg::CTRL_RUN_BIT);
    n = 0;
    do begin
      notes.push_back('{32'h0, 32'h0});
      apb(1'b0, core_pkg::OFF_STATUS, 32'h0000_0000, r);
      n++;
    end while (r[core_pkg::STAT_HALT_BIT] !== 1'b1 && n < 200);
    if (n >= 200) begin
      fails++;
      complete_run();
    end
  endtask
  function automatic logic [15:0] ins(core_pkg::opcode_e op, logic [10:0] f);
    return {op, f};
  endfunction
  task automatic flag(input int b, input logic v);
    rd(core_pkg::OFF_STATUS, 32'(v) << b, 32'h1 << b);
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  core_pkg::opcode_e lop[3] = '{core_pkg::OP_AND_X, core_pkg::OP_OR_X, core_pkg::OP_XOR_M};
  logic [7:0] lx[3] = '{8'h0f, 8'h0f, 8'h10};
  logic [7:0] lexp[3] = '{8'h00, 8'hff, 8'h00};
  initial begin
    logic [7:0] a;
    logic [7:0] b;
    logic [8:0] s;
    void'($urandom(32'hea539fea));
    `CHECK(core_pkg::REF_ONE_CYCLE_NS, 500)
    `CHECK(core_pkg::REF_TWO_CYCLE_NS, 1000)
    for (int k = 0; k < 3; k++) begin
      a = 8'($urandom);
      b = 8'($urandom);
      s = {1'b0, a} + {1'b0, b};
      start();
      prog = '{ins(core_pkg::OP_TO_ACC_X, {3'h0, a}), ins(core_pkg::OP_ADD_X, {3'h0, b}),
               ins(core_pkg::OP_HALT, 11'h000)};
      run();
      rd(core_pkg::OFF_ACC, {24'h0, s[7:0]}, 32'h0000_00ff);
      flag(core_pkg::STAT_C_BIT, s[8]);
      rd(core_pkg::OFF_ICYCLES, 32'h0000_0003, 32'hffff_ffff);
    end
    $display("test add done");
    for (int k = 0; k < 3; k++) begin
      start();
      poke(8'h10, 8'hf0);
      prog = '{ins(core_pkg::OP_TO_ACC_M, 11'h010), ins(lop[k], {3'h0, lx[k]}),
               ins(core_pkg::OP_HALT, 11'h000)};
      run();
      rd(core_pkg::OFF_ACC, {24'h0, lexp[k]}, 32'h0000_00ff);
      flag(core_pkg::STAT_Z_BIT, lexp[k] == 8'h00);
    end
    $display("test logic done");
    start();
    poke(8'h11, 8'hff);
    poke(8'h12, 8'h81);
    poke(8'h13, 8'h5a);
    prog = '{ins(core_pkg::OP_PLUS_M, 11'h011), ins(core_pkg::OP_MINUS_A, 11'h011),
             ins(core_pkg::OP_ADD_X, 11'h001), ins(core_pkg::OP_ROTATE, 11'h612),
             ins(core_pkg::OP_BIT_HIGH, 11'h013), ins(core_pkg::OP_BIT_LOW, 11'h613),
             ins(core_pkg::OP_HALT, 11'h000)};
    run();
    peek(8'h11, 8'h00);
    peek(8'h12, 8'h03);
    flag(core_pkg::STAT_C_BIT, 1'b1);
    peek(8'h13, 8'h1b);
    $display("test modify done");
    start();
    poke(8'h14, 8'h00);
    prog = '{ins(core_pkg::OP_TO_ACC_X, 11'h001), ins(core_pkg::OP_SKIP_ZERO, 11'h014),
             ins(core_pkg::OP_TO_ACC_X, 11'h022), ins(core_pkg::OP_SKIP_BIT_ONE, 11'h014),
             ins(core_pkg::OP_TO_ACC_X, 11'h033), ins(core_pkg::OP_HALT, 11'h000)};
    run();
    rd(core_pkg::OFF_ACC, 32'h0000_0033, 32'h0000_00ff);
    rd(core_pkg::OFF_ICYCLES, 32'h0000_0006, 32'hffff_ffff);
    $display("test skip done");
    start();
    prog = '{ins(core_pkg::OP_CALL, 11'h004), ins(core_pkg::OP_ADD_X, 11'h001),
             ins(core_pkg::OP_TO_MEM, 11'h015), ins(core_pkg::OP_HALT, 11'h000),
             ins(core_pkg::OP_TO_ACC_X, 11'h040), ins(core_pkg::OP_RETURN_INT, 11'h000)};
    run();
    peek(8'h15, 8'h41);
    flag(core_pkg::STAT_GIE_BIT, 1'b1);
    rd(core_pkg::OFF_ICYCLES, 32'h0000_0008, 32'hffff_ffff);
    start();
    prog = '{ins(core_pkg::OP_TO_ACC_X, 11'h004), ins(core_pkg::OP_TO_MEM, 11'h002),
             ins(core_pkg::OP_TO_ACC_X, 11'h077), ins(core_pkg::OP_HALT, 11'h000),
             ins(core_pkg::OP_JUMP, 11'h006), ins(core_pkg::OP_HALT, 11'h000),
             ins(core_pkg::OP_HALT, 11'h000)};
    run();
    rd(core_pkg::OFF_ACC, 32'h0000_0004, 32'h0000_00ff);
    rd(core_pkg::OFF_PC, 32'h0000_0007, 32'h0000_07ff);
    rd(core_pkg::OFF_ICYCLES, 32'h0000_0006, 32'hffff_ffff);
    $display("test branch done");
    repeat (2) @(posedge pclk);
    complete_run();
  end
endmodule
